// >>> rtl/quadrature_counter_index_probe.sv
`timescale 1ns/1ps
`include "qcnt_cfg.svh"

// What this block does
// - Layouts 000,010,011,100 give one counter of 24, 48, 16, 32 bits.
// - Layouts 001,101,110,111 give 24+24, 32+16, 16+16, 16+16+16; last lacks index.
// - Channel-zero source select stops all counting; readout shows exchange data.
// - Index qualification field picks A/B levels 11, 10, 01 or 00.
// - First two index pulses after start clear counters regardless of clear bits.
// - Index-clear bits 5 and 6 let each index clear counter 0 or 1.
// - Input-type bit 7: 0 differential, 1 single-ended.
// - Differential standard bit: 0 RS-422, 1 LVDS, only when differential.
// - Pins map to A, B, index per layout and input type.
// - Swap bits 3..5 exchange A and B of counters 0..2.
// - Invert bits 6 and 7 make index of counter 0 or 1 active low.
// - Hidden 24-bit reference counter runs unless channel-zero source select stops it, cleared by each raw index.
// - Reference counter holds signed distances from -2^23 to 2^23-1.
// - First index zeroes reference, second loads reference value, clears counter.
// - Reference-valid set after second index; cleared by restart or counter 0 reset.
// - Every index loads update distance with the reference count.
// - Update-valid set when loaded and unread, not at the first index after start or restart.
// - Word 0x0A returns update distance and an update-not-valid bit.
// - Probe event shifts first capture into second, loads counter 0.
// - Probe capture needs a 24-bit layout (the code captures in every layout); only counter 0 is latched.
// - Probe edge field: both, rising, falling, or pin disabled.
// - Probe-not-valid bit reads 0 when captures are valid, else 1.
// - Instruction bits act once when written with 1, then read as 0.
module quadrature_counter_index_probe #(
	parameter int unsigned REF_W = 24
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire qcnt_pkg::enc_pins_t i_pins,
	input  wire qcnt_pkg::reg_req_t  i_reg_req,
	output logic [49:0]            o_rd_data,
	output logic                   o_rd_valid,
	output logic                   o_diff_mode,
	output logic                   o_lvds_mode,
	output logic                   o_ref_valid,
	output logic                   o_update_valid,
	output logic                   o_probe_valid
);

	// ============================================================
	// Configuration bytes.
	logic [7:0]  layout_cfg_ff;
	logic [7:0]  input_cfg_ff;
	logic [7:0]  diff_cfg_ff;
	logic [7:0]  chsel_cfg_ff;
	logic [47:0] xchg_ff;

	wire [2:0] layout = layout_cfg_ff[`QC_LAYOUT_LSB +: 3];
	wire [2:0] swap   = layout_cfg_ff[`QC_SWAP_LSB +: 3];
	wire [1:0] invz   = layout_cfg_ff[`QC_INVZ_LSB +: 2];
	wire [1:0] pedge  = input_cfg_ff[`QC_PEDGE_LSB +: 2];
	wire [1:0] qual   = input_cfg_ff[`QC_QUAL_LSB +: 2];
	wire [1:0] cbz    = input_cfg_ff[`QC_CBZ_LSB +: 2];
	wire       ttl    = input_cfg_ff[`QC_TTL_BIT];
	wire       lvds   = diff_cfg_ff[`QC_LVDS_BIT];
	wire       channel_zero_source_select = chsel_cfg_ff[`QC_CHANNEL_ZERO_SOURCE_SELECT_BIT];

	// Layout classes used by pin mapping and index availability.
	wire three = (layout == `QC_L_3X16);
	wire two   = (layout == `QC_L_2X24) || (layout == `QC_L_32_16) ||
		(layout == `QC_L_2X16);

	// Register strobes; instruction bits exist only for the write cycle.
	wire wr = i_reg_req.wr;
	wire rd = i_reg_req.rd;
	wire [6:0] addr = i_reg_req.addr;
	wire instr_wr = wr && (addr == `QC_ADDR_INSTR);
	wire [2:0] abres = instr_wr ?
		i_reg_req.wdata[`QC_INSTR_ABRES_LSB +: 3] : 3'h0;
	wire zero_codification_enable = instr_wr && i_reg_req.wdata[`QC_INSTR_ZERO_CODIFICATION_ENABLE_BIT];
	wire probe_instr = instr_wr && i_reg_req.wdata[`QC_INSTR_PROBE_BIT];
	wire upd_rd   = rd && (addr == `QC_ADDR_UPD);
	wire probe_rd = rd && ((addr == `QC_ADDR_PROBE1) ||
		(addr == `QC_ADDR_PROBE2));

	// Receiver mode straps; LVDS only means something when differential.
	assign o_diff_mode = ~ttl;
	assign o_lvds_mode = ~ttl & lvds;

	// ============================================================
	// Configuration writes.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			layout_cfg_ff <= `QC_CFG_RESET;
			input_cfg_ff  <= `QC_CFG_RESET;
			diff_cfg_ff   <= `QC_CFG_RESET;
			chsel_cfg_ff  <= `QC_CFG_RESET;
		end
		else if (wr)
		begin
			if (addr == `QC_ADDR_LAYOUT)
				layout_cfg_ff <= i_reg_req.wdata;
			else if (addr == `QC_ADDR_INPUT)
				input_cfg_ff <= i_reg_req.wdata;
			else if (addr == `QC_ADDR_DIFF)
				diff_cfg_ff <= i_reg_req.wdata;
			else if (addr == `QC_ADDR_CHSEL)
				chsel_cfg_ff <= i_reg_req.wdata;
		end
	end

	// Exchange bytes, most significant byte at the lowest offset.
	wire [2:0] xbyte = 3'(addr - `QC_ADDR_XCHG_FIRST);
	wire xchg_wr = wr && (addr >= `QC_ADDR_XCHG_FIRST) &&
		(addr <= `QC_ADDR_XCHG_LAST);
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			xchg_ff <= 48'h0;
		else if (xchg_wr)
			xchg_ff[8 * (5 - xbyte) +: 8] <= i_reg_req.wdata;
	end

	// ============================================================
	// Pin synchroniser; the first stage feeds only the second.
	logic [6:0] meta_ff;
	logic [6:0] sync_ff;
	logic [6:0] prev_ff;
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			meta_ff <= 7'h0;
			sync_ff <= 7'h0;
			prev_ff <= 7'h0;
		end
		else
		begin
			meta_ff <= i_pins;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Pin routing, returns {z1,z0,b2,a2,b1,a1,b0,a0}.
	function automatic logic [7:0] map_pins(input logic [6:0] p,
		input logic diff, input logic is3);
		logic ap;
		logic an;
		logic bp;
		logic bn;
		logic cp;
		logic cn;
		{cn, cp, bn, bp, an, ap} = p[5:0];
		map_pins = {cn, (diff ? cp : bp), cn, cp, (is3 ? bn : cp),
			(is3 ? bp : bn), (diff ? bp : an), ap};
	endfunction : map_pins

	wire [7:0] pin_now = map_pins(sync_ff, ~ttl, three);
	wire [7:0] pin_pre = map_pins(prev_ff, ~ttl, three);

	// Width of each counter per layout; zero marks an unused counter.
	function automatic logic [5:0] cnt_width(input logic [2:0] l,
		input int ch);
		logic [17:0] w;
		case (l)
			`QC_L_1X24:  w = {6'd0, 6'd0, 6'd24};
			`QC_L_2X24:  w = {6'd0, 6'd24, 6'd24};
			`QC_L_1X48:  w = {6'd0, 6'd0, 6'd48};
			`QC_L_1X16:  w = {6'd0, 6'd0, 6'd16};
			`QC_L_1X32:  w = {6'd0, 6'd0, 6'd32};
			`QC_L_32_16: w = {6'd0, 6'd16, 6'd32};
			`QC_L_2X16:  w = {6'd0, 6'd16, 6'd16};
			default:     w = {6'd16, 6'd16, 6'd16};
		endcase
		cnt_width = w[6 * ch +: 6];
	endfunction : cnt_width

	// Wraps a value to a signed counter of the given width.
	function automatic logic [47:0] fit(input logic [47:0] v,
		input logic [5:0] w);
		case (w)
			6'd16:   fit = {{32{v[15]}}, v[15:0]};
			6'd24:   fit = {{24{v[23]}}, v[23:0]};
			6'd32:   fit = {{16{v[31]}}, v[31:0]};
			6'd48:   fit = v;
			default: fit = 48'h0;
		endcase
	endfunction : fit

	// ============================================================
	// Zero codification state and reference counter.
	qcnt_pkg::zc_state_t zc_ff;
	qcnt_pkg::zc_state_t nxt_zc;
	logic [REF_W-1:0]    ref_cnt_ff;
	logic [REF_W-1:0]    ref_val_ff;
	logic [REF_W-1:0]    upd_ff;
	logic                ref_valid_ff;
	logic                upd_valid_ff;

	// Per counter decode results.
	logic [47:0] cnt_ff [3];
	logic [2:0]  step;
	logic [2:0]  up;
	logic [2:0]  dbl;
	logic [2:0]  clr;
	logic [1:0]  qual_edge;
	logic        aberr_ff;

	// The raw index of counter 0 drives the reference logic, unqualified.
	wire z0_now = pin_now[6] ^ invz[0];
	wire z0_pre = pin_pre[6] ^ invz[0];
	wire ref_edge = ~three & z0_now & ~z0_pre;
	wire zc_busy = (zc_ff != qcnt_pkg::ZC_DONE);

	// ============================================================
	// Per counter decode, index and count; one lane per counter.
	for (genvar c = 0; c < 3; c++)
	begin : g_ch
		wire a_n = swap[c] ? pin_now[2*c+1] : pin_now[2*c];
		wire b_n = swap[c] ? pin_now[2*c] : pin_now[2*c+1];
		wire a_p = swap[c] ? pin_pre[2*c+1] : pin_pre[2*c];
		wire b_p = swap[c] ? pin_pre[2*c] : pin_pre[2*c+1];
		wire [5:0] w = cnt_width(layout, c);
		wire active = (w != 6'd0) && ~channel_zero_source_select;

		// One changed track is a step; A leading B counts up.
		assign step[c] = (a_n ^ a_p) ^ (b_n ^ b_p);
		assign dbl[c]  = (a_n ^ a_p) & (b_n ^ b_p);
		assign up[c]   = a_n ^ b_p;

		if (c < 2)
		begin : g_idx
			wire has_z = (c == 0) ? ~three : two;
			wire zn = pin_now[6+c] ^ invz[c];
			wire zp = pin_pre[6+c] ^ invz[c];
			wire qn = zn & (a_n == ~qual[1]) & (b_n == ~qual[0]);
			wire qp = zp & (a_p == ~qual[1]) & (b_p == ~qual[0]);
			assign qual_edge[c] = has_z & qn & ~qp;
			assign clr[c] = abres[c] |
				(qual_edge[c] & (zc_busy | cbz[c]));
		end
		else
		begin : g_noidx
			assign clr[c] = abres[c];
		end

		// Clear beats a step taken in the same cycle.
		wire [47:0] nxt_cnt = clr[c] ? 48'h0 :
			(active && step[c]) ?
			fit(cnt_ff[c] + (up[c] ? 48'h1 : 48'hFFFFFFFFFFFF), w) :
			cnt_ff[c];
		always_ff @(posedge i_clk or posedge i_sys_rst)
		begin
			if (i_sys_rst)
				cnt_ff[c] <= 48'h0;
			else
				cnt_ff[c] <= nxt_cnt;
		end
	end

	// Zero codification walk; a new activation restarts it.
	always_comb
	begin
		nxt_zc = zc_ff;
		if (zero_codification_enable)
			nxt_zc = qcnt_pkg::ZC_FIRST;
		else
			case (zc_ff)
				qcnt_pkg::ZC_FIRST:
					if (ref_edge)
						nxt_zc = qcnt_pkg::ZC_SECOND;
				qcnt_pkg::ZC_SECOND:
					if (ref_edge)
						nxt_zc = qcnt_pkg::ZC_DONE;
				default:
					nxt_zc = qcnt_pkg::ZC_DONE;
			endcase
	end

	// Hardware sets win over software clears on all flags below.
	wire ref_set = (zc_ff == qcnt_pkg::ZC_SECOND) && ref_edge;
	wire upd_set = ref_edge && (zc_ff != qcnt_pkg::ZC_FIRST);
	wire nxt_ref_valid = ref_set |
		(ref_valid_ff & ~zero_codification_enable & ~abres[0]);
	wire nxt_upd_valid = upd_set | (upd_valid_ff & ~upd_rd);
	wire aberr_set = dbl[0] & (cnt_width(layout, 0) != 6'd0) & ~channel_zero_source_select;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			zc_ff        <= qcnt_pkg::ZC_FIRST;
			ref_valid_ff <= 1'b0;
			upd_valid_ff <= 1'b0;
			aberr_ff     <= 1'b0;
		end
		else
		begin
			zc_ff        <= nxt_zc;
			ref_valid_ff <= nxt_ref_valid;
			upd_valid_ff <= nxt_upd_valid;
			aberr_ff     <= aberr_set | (aberr_ff & ~abres[0]);
		end
	end

	// Reference counter wraps at 24 bits; overflow reporting lives elsewhere.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ref_cnt_ff <= '0;
			ref_val_ff <= '0;
			upd_ff     <= '0;
		end
		else
		begin
			if (ref_edge)
				ref_cnt_ff <= '0;
			else if (step[0] && ~channel_zero_source_select)
				ref_cnt_ff <= up[0] ? ref_cnt_ff + 1'b1 :
					ref_cnt_ff - 1'b1;
			if (ref_edge)
				upd_ff <= ref_cnt_ff;
			if (ref_set)
				ref_val_ff <= ref_cnt_ff;
		end
	end

	// ============================================================
	// Probe capture pair.
	logic [23:0] probe1_ff;
	logic [23:0] probe2_ff;
	logic        probe_valid_ff;
	wire tp_n = sync_ff[6];
	wire tp_p = prev_ff[6];
	wire pin_evt = (pedge == `QC_PE_BOTH) ? (tp_n ^ tp_p) :
		(pedge == `QC_PE_RISE) ? (tp_n & ~tp_p) :
		(pedge == `QC_PE_FALL) ? (~tp_n & tp_p) : 1'b0;
	wire probe_evt = pin_evt | probe_instr;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			probe1_ff      <= 24'h0;
			probe2_ff      <= 24'h0;
			probe_valid_ff <= 1'b0;
		end
		else
		begin
			if (probe_evt)
			begin
				probe2_ff <= probe1_ff;
				probe1_ff <= cnt_ff[0][23:0];
			end
			probe_valid_ff <= probe_evt | (probe_valid_ff & ~probe_rd);
		end
	end

	// ============================================================
	// Read path; data appears one cycle after the read strobe.
	logic [47:0] readout;
	logic [49:0] nxt_rd;
	logic [49:0] rd_data_ff;
	logic        rd_valid_ff;

	// Counter 0 in the low bits, later counters above it.
	always_comb
	begin
		case (layout)
			`QC_L_2X24:  readout = {cnt_ff[1][23:0], cnt_ff[0][23:0]};
			`QC_L_32_16: readout = {cnt_ff[1][15:0], cnt_ff[0][31:0]};
			`QC_L_2X16:  readout = {16'h0, cnt_ff[1][15:0],
				cnt_ff[0][15:0]};
			`QC_L_3X16:  readout = {cnt_ff[2][15:0], cnt_ff[1][15:0],
				cnt_ff[0][15:0]};
			default:     readout = cnt_ff[0];
		endcase
	end

	always_comb
	begin
		nxt_rd = 50'h0;
		if (addr == `QC_ADDR_LAYOUT)
			nxt_rd = {42'h0, layout_cfg_ff};
		else if (addr == `QC_ADDR_INPUT)
			nxt_rd = {42'h0, input_cfg_ff};
		else if (addr == `QC_ADDR_DIFF)
			nxt_rd = {42'h0, diff_cfg_ff};
		else if (addr == `QC_ADDR_CHSEL)
			nxt_rd = {42'h0, chsel_cfg_ff};
		else if (addr == `QC_ADDR_READOUT)
			nxt_rd = {(channel_zero_source_select ? xchg_ff : readout), 2'h3};
		else if (addr == `QC_ADDR_UPD)
			nxt_rd = {24'h0, upd_ff, ~aberr_ff, ~upd_valid_ff};
		else if (addr == `QC_ADDR_PROBE1)
			nxt_rd = {24'h0, probe1_ff, ~aberr_ff,
				~probe_valid_ff};
		else if (addr == `QC_ADDR_PROBE2)
			nxt_rd = {24'h0, probe2_ff, ~aberr_ff, ~probe_valid_ff};
		else if (addr == `QC_ADDR_REF)
			nxt_rd = {26'h0, ref_val_ff};
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rd_data_ff  <= 50'h0;
			rd_valid_ff <= 1'b0;
		end
		else
		begin
			rd_valid_ff <= rd;
			if (rd)
				rd_data_ff <= nxt_rd;
		end
	end

	assign o_rd_data      = rd_data_ff;
	assign o_rd_valid     = rd_valid_ff;
	assign o_ref_valid    = ref_valid_ff;
	assign o_update_valid = upd_valid_ff;
	assign o_probe_valid  = probe_valid_ff;

	// ============================================================
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	zc_index_clear_a: assert property (zc_busy && qual_edge[0]
		|=> cnt_ff[0] == 48'h0) else $error("index did not clear counter");
	source_hold_a: assert property (channel_zero_source_select && !clr[0]
		|=> cnt_ff[0] == $past(cnt_ff[0])) else $error("counted in exchange");
	upd_load_a: assert property (ref_edge
		|=> upd_ff == $past(ref_cnt_ff) && ref_cnt_ff == '0)
		else $error("update distance not loaded");
	ref_valid_set_a: assert property (ref_set |=> ref_valid_ff
		##0 ref_val_ff == $past(ref_cnt_ff)) else $error("reference missed");
	upd_first_a: assert property (ref_edge && zc_ff == qcnt_pkg::ZC_FIRST
		&& !upd_valid_ff |=> !upd_valid_ff)
		else $error("update flag at first index");
	probe_shift_a: assert property (probe_evt
		|=> probe2_ff == $past(probe1_ff) &&
		probe1_ff == $past(cnt_ff[0][23:0])) else $error("probe shift bad");
	probe_off_a: assert property (
		pedge == `QC_PE_OFF && !probe_instr
		|=> $stable(probe1_ff)) else $error("disabled pin captured");
	upd_read_a: assert property (upd_rd |=> o_rd_valid
		&& o_rd_data[0] == $past(~upd_valid_ff)
		&& o_rd_data[25:2] == $past(upd_ff)) else $error("update word bad");
	count_up_a: assert property (layout == `QC_L_1X24
		&& step[0] && up[0] && !channel_zero_source_select && !clr[0]
		|=> cnt_ff[0][23:0] == $past(cnt_ff[0][23:0]) + 24'h1)
		else $error("count step wrong");

	zc_done_c: cover property (ref_set ##[1:50] probe_evt);
	upd_read_c: cover property (upd_valid_ff ##1 upd_rd);
	three_cnt_c: cover property (three && step[2]);

endmodule : quadrature_counter_index_probe

// >>> shared/qcnt_cfg.svh
`ifndef QCNT_CFG_SVH
`define QCNT_CFG_SVH

// ============================================================
// Register offsets.
`define QC_ADDR_LAYOUT     7'h00
`define QC_ADDR_INPUT      7'h01
`define QC_ADDR_DIFF       7'h03
`define QC_ADDR_CHSEL      7'h04
`define QC_ADDR_READOUT    7'h08
`define QC_ADDR_UPD        7'h0A
`define QC_ADDR_PROBE1     7'h0C
`define QC_ADDR_PROBE2     7'h0E
`define QC_ADDR_REF        7'h10
`define QC_ADDR_XCHG_FIRST 7'h20
`define QC_ADDR_XCHG_LAST  7'h25
`define QC_ADDR_INSTR      7'h30

// ============================================================
// Reset value shared by every configuration byte.
`define QC_CFG_RESET       8'h00

// ============================================================
// Field positions.
`define QC_LAYOUT_LSB      0
`define QC_SWAP_LSB        3
`define QC_INVZ_LSB        6
`define QC_PEDGE_LSB       1
`define QC_QUAL_LSB        3
`define QC_CBZ_LSB         5
`define QC_TTL_BIT         7
`define QC_LVDS_BIT        7
`define QC_CHANNEL_ZERO_SOURCE_SELECT_BIT      3
`define QC_INSTR_ABRES_LSB 0
`define QC_INSTR_ZERO_CODIFICATION_ENABLE_BIT  3
`define QC_INSTR_PROBE_BIT 4

// ============================================================
// Counter layout codes.
`define QC_L_1X24          3'h0
`define QC_L_2X24          3'h1
`define QC_L_1X48          3'h2
`define QC_L_1X16          3'h3
`define QC_L_1X32          3'h4
`define QC_L_32_16         3'h5
`define QC_L_2X16          3'h6
`define QC_L_3X16          3'h7

// ============================================================
// Probe pin edge codes.
`define QC_PE_BOTH         2'h0
`define QC_PE_RISE         2'h1
`define QC_PE_FALL         2'h2
`define QC_PE_OFF          2'h3

`endif

// >>> shared/qcnt_pkg.sv
package qcnt_pkg;

	// ============================================================
	// Register request carried as one bundle.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Encoder and probe pins, already resolved to logic levels.
	typedef struct packed {
		logic probe_trigger_pin;
		logic cn;
		logic cp;
		logic bn;
		logic bp;
		logic an;
		logic ap;
	} enc_pins_t;

	// Zero codification progress.
	typedef enum logic [1:0] {
		ZC_FIRST,
		ZC_SECOND,
		ZC_DONE
	} zc_state_t;

endpackage : qcnt_pkg

// >>> tb/enc_model.sv
`timescale 1ns/1ps

// ============================================================
// Encoder with differential A, B and index tracks plus a probe pin.
module enc_model (
	input  wire logic           i_clk,
	input  wire logic           i_step,
	input  wire logic           i_fwd,
	input  wire logic           i_z,
	input  wire logic           i_tpi,
	input  wire logic           i_ttl,
	output qcnt_pkg::enc_pins_t o_pins
);
	logic [1:0] ph_ff = 2'h0;
	wire  logic a = ph_ff[0] ^ ph_ff[1];
	wire  logic b = ph_ff[1];

	// One track moves per step, so A and B never change together.
	always @(posedge i_clk)
	begin
		if (i_step)
			ph_ff <= i_fwd ? ph_ff + 2'h1 : ph_ff - 2'h1;
	end

	// Single counter only; single-ended moves B to the second pin and the
	// index to the third, leaving the spare pins as in differential mode.
	qcnt_pkg::enc_pins_t diff_pins;
	qcnt_pkg::enc_pins_t se_pins;
	assign diff_pins = '{probe_trigger_pin: i_tpi, cn: !i_z, cp: i_z, bn: !b, bp: b,
		an: !a, ap: a};
	assign se_pins = '{probe_trigger_pin: i_tpi, cn: !i_z, cp: i_z, bn: !b, bp: i_z,
		an: b, ap: a};
	assign o_pins = i_ttl ? se_pins : diff_pins;
endmodule : enc_model

// >>> tb/tb.sv
`timescale 1ns/1ps

// ============================================================
// Self-checking bench for the quadrature counter core.
module tb;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	qcnt_pkg::reg_req_t  req = '0;
	qcnt_pkg::enc_pins_t pins;
	logic                step = 1'b0;
	logic                fwd = 1'b0;
	logic                z = 1'b0;
	logic                probe_trigger_pin = 1'b0;
	logic                se_mode = 1'b0;
	logic [49:0]         rdata;
	logic                rd_valid, diff, lvds, refv, updv, prbv;
	logic [31:0]         seed = 32'h32A77A10;
	logic [47:0]         xw;
	logic [7:0]          cfg0 = 8'h00;
	logic [7:0]          cfg1 = 8'h00;
	logic [6:0]          ra [6] = '{7'h00, 7'h01, 7'h03, 7'h04, 7'h05, 7'h30};
	bit                  e_ref, e_upd, e_prb, ch0;
	int                  bad_count = 0;
	int                  n_tests = 0;
	int                  cyc = 0;
	int                  cnt = 0, refc = 0, refreg = 0, update_distance_word = 0;
	int                  tp1 = 0, tp2 = 0, zc = 0, nidx = 0, ph = 0, k;

	// Clock at 125 MHz.
	always #4 clk = !clk;

	// A hang still ends in the verdict, counted as a mismatch.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
	end

	quadrature_counter_index_probe uut (
		.i_clk          (clk),
		.i_sys_rst      (rst),
		.i_pins         (pins),
		.i_reg_req      (req),
		.o_rd_data      (rdata),
		.o_rd_valid     (rd_valid),
		.o_diff_mode    (diff),
		.o_lvds_mode    (lvds),
		.o_ref_valid    (refv),
		.o_update_valid (updv),
		.o_probe_valid  (prbv)
	);

	enc_model enc (
		.i_clk  (clk),
		.i_step (step),
		.i_fwd  (fwd),
		.i_z    (z),
		.i_tpi  (probe_trigger_pin),
		.i_ttl  (se_mode),
		.o_pins (pins)
	);

	// ============================================================
	// Helpers.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [49:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// The #1 lets the edge that takes the write settle before checks.
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		req <= '0;
		#1;
	endtask : wr

	task automatic rchk(input logic [6:0] a, input logic [49:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		chk("read strobe", 50'h1, rd_valid);
		chk("read data", e, rdata);
	endtask : rchk

	task automatic cchk();
		rchk(7'h08, {{24{cnt[23]}}, cnt[23:0], 2'b11});
	endtask : cchk

	// Reads the second capture first, so the first read sees valid data.
	task automatic pchk();
		rchk(7'h0E, {24'h0, tp2[23:0], 1'b1, !e_prb});
		e_prb = 0;
		rchk(7'h0C, {24'h0, tp1[23:0], 2'b11});
	endtask : pchk

	// One quadrature step; the model mirrors swap and the source select.
	task automatic stp(input bit f);
		int s;
		s = (f ^ cfg0[3]) ? 1 : -1;
		@(posedge clk);
		step <= 1'b1;
		fwd <= f;
		@(posedge clk);
		step <= 1'b0;
		repeat (2) @(posedge clk);
		ph = (ph + (f ? 1 : 3)) % 4;
		if (!ch0)
		begin
			cnt += s;
			refc += s;
		end
	endtask : stp

	// Index pulse; qualification only gates counter clearing.
	task automatic idx();
		bit m;
		m = ((ph == 1 || ph == 2) == !cfg1[4]) && ((ph >= 2) == !cfg1[3]);
		@(posedge clk);
		z <= 1'b1;
		repeat (4) @(posedge clk);
		z <= 1'b0;
		repeat (4) @(posedge clk);
		update_distance_word = refc;
		e_upd |= nidx > 0;
		nidx++;
		if (zc == 1)
		begin
			refreg = refc;
			e_ref = 1;
		end
		if (m && (zc < 2 || cfg1[5]))
			cnt = 0;
		if (zc < 2)
			zc++;
		refc = 0;
	endtask : idx

	task automatic tp(input logic v, input bit hit);
		@(posedge clk);
		probe_trigger_pin <= v;
		repeat (4) @(posedge clk);
		if (hit)
		begin
			tp2 = tp1;
			tp1 = cnt;
			e_prb = 1;
		end
	endtask : tp

	// ============================================================
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("diff mode", 1'b1, diff);
		chk("lvds mode", 1'b0, lvds);
		chk("ref valid", 1'b0, refv);
		chk("update valid", 1'b0, updv);
		for (k = 0; k < 6; k++)
			rchk(ra[k], 50'h0);
		wr(7'h03, 8'h80);
		chk("lvds mode", 1'b1, lvds);
		rchk(7'h03, 50'h80);
		wr(7'h01, 8'h80);
		chk("diff mode", 1'b0, diff);
		chk("lvds mode", 1'b0, lvds);
		wr(7'h01, 8'h00);
		wr(7'h03, 8'h00);
		wr(7'h0A, 8'hFF);
		rchk(7'h0A, 50'h3);
		// Random walk, read back every fourth step.
		for (k = 0; k < 24; k++)
		begin
			stp(1'(xs()));
			if (k % 4 == 3)
				cchk();
		end
		wr(7'h00, 8'h08);
		cfg0 = 8'h08;
		repeat (3) stp(1'b1);
		cchk();
		repeat (3) stp(1'b0);
		wr(7'h00, 8'h00);
		cfg0 = 8'h00;
		// Zero codification after power-on.
		while (ph != 2)
			stp(1'b1);
		idx();
		chk("ref valid", 1'b0, refv);
		chk("update valid", 1'b0, updv);
		cchk();
		repeat (8) stp(1'b0);
		idx();
		chk("ref valid", e_ref, refv);
		chk("update valid", e_upd, updv);
		rchk(7'h10, {26'h0, refreg[23:0]});
		cchk();
		rchk(7'h0A, {24'h0, update_distance_word[23:0], 1'b1, !e_upd});
		e_upd = 0;
		chk("update valid", 1'b0, updv);
		repeat (4) stp(1'b1);
		idx();
		cchk();
		// Every qualification code against every phase, clearing enabled.
		for (k = 0; k < 16; k++)
		begin
			cfg1 = 8'h20 | 8'((k / 4) << 3);
			wr(7'h01, cfg1);
			stp(1'b1);
			idx();
			cchk();
		end
		wr(7'h01, 8'h00);
		cfg1 = 8'h00;
		// Restart by instruction, then counter 0 reset.
		wr(7'h30, 8'h08);
		zc = 0;
		e_ref = 0;
		chk("ref valid", 1'b0, refv);
		repeat (2)
		begin
			repeat (4) stp(1'b1);
			idx();
		end
		cchk();
		chk("ref valid", e_ref, refv);
		rchk(7'h10, {26'h0, refreg[23:0]});
		repeat (2) stp(1'b1);
		wr(7'h30, 8'h01);
		cnt = 0;
		e_ref = 0;
		cchk();
		chk("ref valid", 1'b0, refv);
		// Probe by instruction, then by pin with each edge code.
		repeat (3) stp(1'b1);
		wr(7'h30, 8'h10);
		tp2 = tp1;
		tp1 = cnt;
		e_prb = 1;
		chk("probe valid", 1'b1, prbv);
		pchk();
		chk("probe valid", 1'b0, prbv);
		for (k = 0; k < 4; k++)
		begin
			wr(7'h01, 8'(k << 1));
			stp(1'b1);
			tp(1'b1, k < 2);
			stp(1'b1);
			tp(1'b0, k == 0 || k == 2);
			pchk();
		end
		// Exchange channel: counting stops while it is selected.
		wr(7'h04, 8'h08);
		ch0 = 1;
		for (k = 0; k < 6; k++)
		begin
			xw[47 - 8 * k -: 8] = 8'(xs());
			wr(7'(7'h20 + k), xw[47 - 8 * k -: 8]);
		end
		repeat (3) stp(1'b1);
		rchk(7'h08, {xw, 2'b11});
		wr(7'h04, 8'h00);
		ch0 = 0;
		cchk();
		// Single-ended 1x16 with inverted index; switched where pins agree.
		while (ph != 1)
			stp(1'b1);
		wr(7'h01, 8'hA0);
		@(posedge clk);
		se_mode <= 1'b1;
		wr(7'h00, 8'h43);
		@(posedge clk);
		z <= 1'b1;
		repeat (4) @(posedge clk);
		stp(1'b1);
		cchk();
		@(posedge clk);
		z <= 1'b0;
		repeat (4) @(posedge clk);
		cnt = 0;
		update_distance_word = refc;
		refc = 0;
		cchk();
		rchk(7'h0A, {24'h0, update_distance_word[23:0], 2'b10});
		test_done();
	end
endmodule : tb
